/* File: core/pwr_gate_pkg.sv */
/*
 * shared constants for the power gating and reset companion block:
 * register layout, reset values and reset timing counts.
 * assumes a 200 MHz clock on both ends.
 */
package pwr_gate_pkg;

   // ********************************************
   // register selection on the host bus
   // ********************************************
   localparam logic       REG_SEL_A        = 1'h0;
   localparam logic       REG_SEL_B        = 1'h1;
   localparam logic [7:0] REG_A_RESET      = 8'h00;
   localparam logic [7:0] REG_B_RESET      = 8'h00;

   // ********************************************
   // field positions
   // ********************************************
   localparam int A_SPEED_OFF_BIT   = 3;
   localparam int A_ARRAY_CLK_BIT   = 4;
   localparam int A_MCELL_CLK_BIT   = 5;
   localparam int B_FIRST_BLOCK_BIT = 2;
   localparam int B_BLOCK_COUNT     = 5;
   localparam logic [7:0] REG_A_USED_MASK = 8'h38;
   localparam logic [7:0] REG_B_USED_MASK = 8'h7C;

   // ********************************************
   // timing
   // ********************************************
   localparam int CLOCK_MHZ             = 200;
   localparam int IDLE_STANDBY_NS       = 100;
   localparam int IDLE_STANDBY_CYCLES   =
      (IDLE_STANDBY_NS * CLOCK_MHZ + 999) / 1000;
   localparam int RESET_RECOVERY_NS     = 100;
   localparam int RESET_RECOVERY_CYCLES =
      (RESET_RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
   localparam int WARM_PULSE_NS         = 50;
   localparam int WARM_PULSE_CYCLES     =
      (WARM_PULSE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int POWERON_PULSE_NS      = 1000;
   localparam int POWERON_PULSE_CYCLES  =
      (POWERON_PULSE_NS * CLOCK_MHZ + 999) / 1000;
   localparam int CONFIG_LOAD_CYCLES    = 16;

   typedef enum logic [1:0]
   {
      ST_LOADING = 2'b00,
      ST_RUN     = 2'b01,
      ST_WARM    = 2'b10
   } dev_state_t;

   typedef enum logic [2:0]
   {
      H_POWERON  = 3'b000,
      H_RECOVER  = 3'b001,
      H_READY    = 3'b010,
      H_WARM     = 3'b011,
      H_ACCESS   = 3'b100
   } host_state_t;

endpackage

/* File: core/pwr_gate_if.sv */
/*
 * link between the host end and the device end: host bus strobes,
 * register port, resets, chip select and the flash sector selects.
 * assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface pwr_gate_if;
   logic       poweron_resetn;
   logic       warm_resetn;
   logic       host_write_strobe_n;
   logic       host_read_strobe_n;
   logic       host_control_strobe_c;
   logic       chip_select_n;
   logic [7:0] flash_sector_selects;
   logic       reg_sel;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;

   modport device
   (
      input  poweron_resetn,
      input  warm_resetn,
      input  host_write_strobe_n,
      input  host_read_strobe_n,
      input  host_control_strobe_c,
      input  chip_select_n,
      input  flash_sector_selects,
      input  reg_sel,
      input  reg_wdata,
      output reg_rdata
   );

   modport host
   (
      output poweron_resetn,
      output warm_resetn,
      output host_write_strobe_n,
      output host_read_strobe_n,
      output host_control_strobe_c,
      output chip_select_n,
      output flash_sector_selects,
      output reg_sel,
      output reg_wdata,
      input  reg_rdata
   );
endinterface
`default_nettype wire

/* File: core/pwr_gate_device.sv */
/*
 * device end: power mode registers, input blocking toward the logic
 * arrays, idle-input standby, power-on and warm reset handling.
 * assumes host strobes arrive asynchronously and pass a synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module pwr_gate_device
   import pwr_gate_pkg::*;
(
   input  wire logic       clock,
   pwr_gate_if.device      link,
   input  wire logic       pld_clock_input,
   input  wire logic       port_d_pin_zero,
   input  wire logic       port_c_pin_seven,
   input  wire logic       mcell_next,
   input  wire logic       mcell_clear_eq,
   input  wire logic       mcell_preset_eq,
   output logic [4:0]      pld_array_inputs,
   output logic            pld_array_clock,
   output logic            pld_mcell_clock,
   output logic            flash_write_strobe_n,
   output logic            flash_read_strobe_n,
   output logic            flash_selected,
   output logic            pld_standby,
   output logic            pld_outputs_valid,
   output logic            flash_read_array,
   output logic            output_macrocell
);

   // ********************************************
   // input synchronisers, three stages each
   // ********************************************
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] s1_ff;
   logic [NSYNC-1:0] s2_ff;
   logic [NSYNC-1:0] s3_ff;
   logic [NSYNC-1:0] clean_ff;
   logic [NSYNC-1:0] nxt_clean;

   assign raw_in = {link.chip_select_n, link.warm_resetn,
                    link.host_write_strobe_n, link.host_read_strobe_n,
                    link.host_control_strobe_c, port_d_pin_zero,
                    port_c_pin_seven, pld_clock_input, mcell_clear_eq,
                    mcell_preset_eq};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         // a change counts only once stages two and three agree
         assign nxt_clean[gi] = (s2_ff[gi] == s3_ff[gi]) ?
                                s3_ff[gi] : clean_ff[gi];
      end
   endgenerate

   always_ff @(posedge clock or negedge link.poweron_resetn)
   begin
      if (!link.poweron_resetn)
      begin
         s1_ff    <= 10'h3FF;
         s2_ff    <= 10'h3FF;
         s3_ff    <= 10'h3FF;
         clean_ff <= 10'h3FF;
      end
      else
      begin
         s1_ff    <= raw_in;
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         clean_ff <= nxt_clean;
      end
   end

   logic cs_n_s, warm_n_s, wr_n_s, rd_n_s, c_s, pd0_s, pc7_s, clk_s;
   logic clr_s, pre_s;
   assign {cs_n_s, warm_n_s, wr_n_s, rd_n_s, c_s, pd0_s, pc7_s, clk_s,
           clr_s, pre_s} = clean_ff;

   // ********************************************
   // reset sequencing
   // ********************************************
   dev_state_t state_ff;
   dev_state_t nxt_state;
   logic [4:0] load_cnt_ff;
   logic [4:0] nxt_load_cnt;
   wire        load_done = (load_cnt_ff == 5'(CONFIG_LOAD_CYCLES - 1));

   // configuration is loaded for a fixed time after power-on release
   assign nxt_load_cnt = (state_ff == ST_LOADING && !load_done) ?
                         load_cnt_ff + 5'h01 : load_cnt_ff;

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_LOADING: if (load_done) nxt_state = ST_RUN;
         ST_RUN:     if (!warm_n_s) nxt_state = ST_WARM;
         ST_WARM:    if (warm_n_s) nxt_state = ST_RUN;
         default:    nxt_state = ST_LOADING;
      endcase
   end

   always_ff @(posedge clock or negedge link.poweron_resetn)
   begin
      if (!link.poweron_resetn)
      begin
         state_ff    <= ST_LOADING;
         load_cnt_ff <= 5'h00;
      end
      else
      begin
         state_ff    <= nxt_state;
         load_cnt_ff <= nxt_load_cnt;
      end
   end

   // ********************************************
   // power mode registers
   // ********************************************
   logic [7:0] reg_a_ff;
   logic [7:0] reg_b_ff;
   logic [7:0] rdata_ff;
   logic       wr_d_ff;
   wire        running  = (state_ff == ST_RUN);
   // write lands on the rising edge of the write strobe
   wire        wr_rise  = wr_n_s && !wr_d_ff;
   wire        reg_wr   = wr_rise && !cs_n_s && running;
   wire        wr_a     = reg_wr && (link.reg_sel == REG_SEL_A);
   wire        wr_b     = reg_wr && (link.reg_sel == REG_SEL_B);
   wire [7:0]  nxt_reg_a = wr_a ? (link.reg_wdata & REG_A_USED_MASK)
                                : reg_a_ff;
   wire [7:0]  nxt_reg_b = wr_b ? (link.reg_wdata & REG_B_USED_MASK)
                                : reg_b_ff;
   wire [7:0]  sel_rdata = (link.reg_sel == REG_SEL_A) ? reg_a_ff
                                                       : reg_b_ff;

   // only power-on clears these; warm reset leaves them alone
   always_ff @(posedge clock or negedge link.poweron_resetn)
   begin
      if (!link.poweron_resetn)
      begin
         reg_a_ff <= REG_A_RESET;
         reg_b_ff <= REG_B_RESET;
         rdata_ff <= 8'h00;
         wr_d_ff  <= 1'h1;
      end
      else
      begin
         reg_a_ff <= nxt_reg_a;
         reg_b_ff <= nxt_reg_b;
         rdata_ff <= sel_rdata;
         wr_d_ff  <= wr_n_s;
      end
   end
   assign link.reg_rdata = rdata_ff;

   // ********************************************
   // gating toward the logic arrays
   // ********************************************
   wire [4:0] gate_src = {pc7_s, pd0_s, c_s, rd_n_s, wr_n_s};
   wire [4:0] blocks   = reg_b_ff[B_FIRST_BLOCK_BIT +: B_BLOCK_COUNT];
   // blocked inputs are frozen low so they stop toggling the array
   wire [4:0] nxt_array_in = gate_src & ~blocks;
   wire nxt_arr_clk = clk_s & ~reg_a_ff[A_ARRAY_CLK_BIT];
   wire nxt_mc_clk  = clk_s & ~reg_a_ff[A_MCELL_CLK_BIT];

   // ********************************************
   // idle detection for standby
   // ********************************************
   logic [4:0] prev_in_ff;
   logic       prev_clk_ff;
   logic [7:0] idle_cnt_ff;
   wire        in_change = (nxt_array_in != prev_in_ff) ||
                           (nxt_arr_clk != prev_clk_ff);
   wire        idle_full = (idle_cnt_ff >= 8'(IDLE_STANDBY_CYCLES));
   wire [7:0]  nxt_idle  = in_change ? 8'h00 :
                           (idle_full ? idle_cnt_ff : idle_cnt_ff + 8'h01);
   wire        speed_off = reg_a_ff[A_SPEED_OFF_BIT];
   wire        nxt_standby = speed_off && idle_full && !in_change;

   // ********************************************
   // macrocell and status outputs
   // ********************************************
   logic mcell_ff;
   wire  nxt_mcell = clr_s ? 1'h0 : (pre_s ? 1'h1 :
                     (nxt_mc_clk && !pld_mcell_clock ? mcell_next
                                                     : mcell_ff));

   always_ff @(posedge clock or negedge link.poweron_resetn)
   begin
      if (!link.poweron_resetn)
      begin
         pld_array_inputs     <= 5'h00;
         pld_array_clock      <= 1'h0;
         pld_mcell_clock      <= 1'h0;
         prev_in_ff           <= 5'h00;
         prev_clk_ff          <= 1'h0;
         idle_cnt_ff          <= 8'h00;
         pld_standby          <= 1'h0;
         mcell_ff             <= 1'h0;
         output_macrocell     <= 1'h0;
         pld_outputs_valid    <= 1'h0;
         flash_read_array     <= 1'h1;
         flash_write_strobe_n <= 1'h1;
         flash_read_strobe_n  <= 1'h1;
         flash_selected       <= 1'h0;
      end
      else
      begin
         // logic path ignores chip select entirely
         pld_array_inputs     <= nxt_array_in;
         pld_array_clock      <= nxt_arr_clk;
         pld_mcell_clock      <= nxt_mc_clk;
         prev_in_ff           <= nxt_array_in;
         prev_clk_ff          <= nxt_arr_clk;
         idle_cnt_ff          <= nxt_idle;
         pld_standby          <= nxt_standby;
         mcell_ff             <= nxt_mcell;
         output_macrocell     <= nxt_mcell;
         pld_outputs_valid    <= (nxt_state != ST_LOADING);
         flash_read_array     <= flash_read_array;
         flash_write_strobe_n <= wr_n_s;
         flash_read_strobe_n  <= rd_n_s;
         flash_selected       <= !cs_n_s && (nxt_state == ST_RUN);
      end
   end

endmodule
`default_nettype wire

/* File: core/pwr_gate_host.sv */
/*
 * host end: drives power-on and warm reset, waits the recovery time,
 * then performs register writes and reads on request from its user.
 * assumes the device end samples the strobes through a synchroniser.
 */
`timescale 1ns/1ps
`default_nettype none
module pwr_gate_host
   import pwr_gate_pkg::*;
#(
   parameter int POWERON_CYCLES = POWERON_PULSE_CYCLES
)
(
   input  wire logic       clock,
   input  wire logic       resetn,
   pwr_gate_if.host        link,
   input  wire logic       cmd_write,
   input  wire logic       cmd_read,
   input  wire logic       cmd_warm_reset,
   input  wire logic       cmd_sel,
   input  wire logic [7:0] cmd_wdata,
   output logic            ready,
   output logic            done,
   output logic [7:0]      rdata
);

   // ********************************************
   // sequencer
   // ********************************************
   localparam int HOLD = 8;   // strobe low time, covers device sync
   host_state_t state_ff;
   host_state_t nxt_state;
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic        is_read_ff;
   logic        sel_ff;
   logic [7:0]  wdata_ff;

   wire cnt_zero = (cnt_ff == 16'h0000);

   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_zero ? cnt_ff : cnt_ff - 16'h0001;
      case (state_ff)
         H_POWERON: if (cnt_zero)
            begin
               nxt_state = H_RECOVER;
               nxt_cnt   = 16'(RESET_RECOVERY_CYCLES + CONFIG_LOAD_CYCLES
                               + 8);
            end
         H_RECOVER: if (cnt_zero) nxt_state = H_READY;
         H_READY:
            if (cmd_warm_reset)
            begin
               nxt_state = H_WARM;
               nxt_cnt   = 16'(WARM_PULSE_CYCLES + 4);
            end
            else if (cmd_write || cmd_read)
            begin
               nxt_state = H_ACCESS;
               nxt_cnt   = 16'(HOLD);
            end
         H_WARM: if (cnt_zero)
            begin
               nxt_state = H_RECOVER;
               nxt_cnt   = 16'(RESET_RECOVERY_CYCLES + 8);
            end
         H_ACCESS: if (cnt_zero)
            begin
               nxt_state = H_RECOVER;
               nxt_cnt   = 16'(HOLD);
            end
         default: nxt_state = H_POWERON;
      endcase
   end

   wire take = (state_ff == H_READY) && !cmd_warm_reset &&
               (cmd_write || cmd_read);

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         state_ff   <= H_POWERON;
         cnt_ff     <= 16'(POWERON_CYCLES);
         is_read_ff <= 1'h0;
         sel_ff     <= 1'h0;
         wdata_ff   <= 8'h00;
      end
      else
      begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         is_read_ff <= take ? cmd_read : is_read_ff;
         sel_ff     <= take ? cmd_sel : sel_ff;
         // unused bits forced to zero before they leave
         wdata_ff   <= take ? (cmd_wdata & (cmd_sel ? REG_B_USED_MASK
                                          : REG_A_USED_MASK)) : wdata_ff;
      end
   end

   // ********************************************
   // pin drive from flip-flops; control strobe and sector selects tied low
   // ********************************************
   logic por_n_ff, warm_n_ff, wr_n_ff, rd_n_ff, cs_n_ff, done_ff;
   logic [7:0] rdata_ff;
   wire acc = (nxt_state == H_ACCESS);
   wire fin = (state_ff == H_ACCESS) && cnt_zero;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         por_n_ff  <= 1'h0;
         warm_n_ff <= 1'h1;
         wr_n_ff   <= 1'h1;
         rd_n_ff   <= 1'h1;
         cs_n_ff   <= 1'h1;
         done_ff   <= 1'h0;
         rdata_ff  <= 8'h00;
      end
      else
      begin
         por_n_ff  <= (nxt_state != H_POWERON);
         warm_n_ff <= (nxt_state != H_WARM);
         wr_n_ff   <= !(acc && !(take ? cmd_read : is_read_ff));
         rd_n_ff   <= !(acc && (take ? cmd_read : is_read_ff));
         // select outlasts the strobe, so the write edge is still selected
         cs_n_ff   <= !(acc || fin);
         done_ff   <= fin;
         rdata_ff  <= (fin && is_read_ff) ? link.reg_rdata : rdata_ff;
      end
   end

   assign link.poweron_resetn        = por_n_ff;
   assign link.warm_resetn           = warm_n_ff;
   assign link.host_write_strobe_n   = wr_n_ff;
   assign link.host_read_strobe_n    = rd_n_ff;
   assign link.host_control_strobe_c = 1'h0;
   assign link.chip_select_n         = cs_n_ff;
   assign link.flash_sector_selects  = 8'h00;
   assign link.reg_sel               = sel_ff;
   assign link.reg_wdata             = wdata_ff;
   assign ready = (state_ff == H_READY);
   assign done  = done_ff;
   assign rdata = rdata_ff;

endmodule
`default_nettype wire

/* File: tb/pwr_gate_properties.sv */
/*
 * link checker for the power gating pair: reset, strobe and register
 * port rules seen on the shared interface.
 * assumes one clock and the host reset as the checker's reset.
 */
`timescale 1ns/1ps
`default_nettype none
module pwr_gate_properties
   import pwr_gate_pkg::*;
#(
   parameter int POWERON_CYCLES = POWERON_PULSE_CYCLES
)
(
   input wire logic       clock,
   input wire logic       resetn,
   input wire logic       poweron_resetn,
   input wire logic       warm_resetn,
   input wire logic       host_write_strobe_n,
   input wire logic       host_read_strobe_n,
   input wire logic       chip_select_n,
   input wire logic [7:0] flash_sector_selects,
   input wire logic       reg_sel,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // ********************************************
   // helper counters
   // ********************************************
   int since_rst_ff;
   int low_cnt_ff;

   // saturate so long runs never wrap into a false recovery window
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         since_rst_ff <= 0;
         low_cnt_ff   <= 0;
      end
      else
      begin
         since_rst_ff <= (!poweron_resetn || !warm_resetn) ? 0 :
                         (since_rst_ff < 1000) ? since_rst_ff + 1 :
                         since_rst_ff;
         low_cnt_ff   <= poweron_resetn ? low_cnt_ff : low_cnt_ff + 1;
      end
   end

   // ********************************************
   // properties
   // ********************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   chk_recovery_wait: assert property (
      (!host_write_strobe_n || !host_read_strobe_n)
      |-> since_rst_ff >= RESET_RECOVERY_CYCLES)
      else $error("strobe inside recovery time");
   chk_poweron_quiet: assert property (
      !poweron_resetn |-> flash_sector_selects == 8'h00
      && host_write_strobe_n)
      else $error("selects or write strobe active in power-on");
   chk_poweron_width: assert property (
      $rose(poweron_resetn) |-> low_cnt_ff >= POWERON_CYCLES - 1)
      else $error("power-on pulse too short");
   chk_warm_width: assert property (
      $fell(warm_resetn) |-> (!warm_resetn)[*8] ##[1:40] warm_resetn)
      else $error("warm pulse width wrong");
   chk_unused_read: assert property (
      (reg_rdata & ~($past(reg_sel) ? REG_B_USED_MASK : REG_A_USED_MASK))
      == 8'h00)
      else $error("unused register bit reads one");
   chk_unused_write: assert property (
      (!host_write_strobe_n && reg_sel)
      |-> (reg_wdata & ~REG_B_USED_MASK) == 8'h00)
      else $error("unused bit written as one");
   chk_write_hold: assert property (
      $fell(host_write_strobe_n) |-> !chip_select_n ##1
      (!host_write_strobe_n && !chip_select_n && $stable(reg_wdata))[*7])
      else $error("write cycle not held");
   chk_access_gap: assert property (
      ($rose(host_write_strobe_n) || $rose(host_read_strobe_n))
      |-> ##1 (host_write_strobe_n && host_read_strobe_n)[*8])
      else $error("accesses too close");
   chk_one_strobe: assert property (
      host_write_strobe_n || host_read_strobe_n)
      else $error("both strobes low");
   chk_warm_keeps: assert property (
      (!warm_resetn && !$past(warm_resetn)
      && $past(reg_sel) == $past(reg_sel, 2)) |-> $stable(reg_rdata))
      else $error("register changed in warm reset");
endmodule
`default_nettype wire

/* File: tb/pld_power_gating_and_reset_bench.sv */
/*
 * bench for the host and device ends joined by their interface.
 * assumes a 200 MHz clock; device pins are driven here.
 */
`timescale 1ns/1ps
`default_nettype none
module pld_power_gating_and_reset_bench
   import pwr_gate_pkg::*;
;
   logic       clock, resetn, cmd_write, cmd_read, cmd_warm_reset, cmd_sel;
   logic       ready, done, clk_en, pld_clock_input, port_d_pin_zero;
   logic       port_c_pin_seven, mcell_next, mcell_clear_eq, mcell_preset_eq;
   logic       pld_array_clock, pld_mcell_clock, flash_write_strobe_n;
   logic       flash_read_strobe_n, flash_selected, pld_standby;
   logic       pld_outputs_valid, flash_read_array, output_macrocell;
   logic       sel_seen, wlow_seen, valid_low, arr_seen, mc_seen;
   logic       rlow_seen, clk_ph;
   logic [4:0] pld_array_inputs;
   logic [7:0] cmd_wdata, rdata, v;
   logic [8:0] note;
   logic [8:0] note_q[$];
   logic [3:0] mc_tbl[5] = '{4'b1001, 4'b0000, 4'b1100, 4'b0011, 4'b0110};
   int         n_mismatch, n_tests, seed;

   pwr_gate_if u_pwr_gate_if();
   pwr_gate_host #(.POWERON_CYCLES(20)) u_pwr_gate_host
   (
      .clock(clock), .resetn(resetn), .link(u_pwr_gate_if),
      .cmd_write(cmd_write), .cmd_read(cmd_read),
      .cmd_warm_reset(cmd_warm_reset), .cmd_sel(cmd_sel),
      .cmd_wdata(cmd_wdata), .ready(ready), .done(done), .rdata(rdata)
   );
   pwr_gate_device u_pwr_gate_device
   (
      .clock(clock), .link(u_pwr_gate_if),
      .pld_clock_input(pld_clock_input), .port_d_pin_zero(port_d_pin_zero),
      .port_c_pin_seven(port_c_pin_seven), .mcell_next(mcell_next),
      .mcell_clear_eq(mcell_clear_eq), .mcell_preset_eq(mcell_preset_eq),
      .pld_array_inputs(pld_array_inputs), .pld_array_clock(pld_array_clock),
      .pld_mcell_clock(pld_mcell_clock),
      .flash_write_strobe_n(flash_write_strobe_n),
      .flash_read_strobe_n(flash_read_strobe_n),
      .flash_selected(flash_selected), .pld_standby(pld_standby),
      .pld_outputs_valid(pld_outputs_valid),
      .flash_read_array(flash_read_array), .output_macrocell(output_macrocell)
   );
   pwr_gate_properties #(.POWERON_CYCLES(20)) u_pwr_gate_properties
   (
      .clock(clock), .resetn(resetn),
      .poweron_resetn(u_pwr_gate_if.poweron_resetn),
      .warm_resetn(u_pwr_gate_if.warm_resetn),
      .host_write_strobe_n(u_pwr_gate_if.host_write_strobe_n),
      .host_read_strobe_n(u_pwr_gate_if.host_read_strobe_n),
      .chip_select_n(u_pwr_gate_if.chip_select_n),
      .flash_sector_selects(u_pwr_gate_if.flash_sector_selects),
      .reg_sel(u_pwr_gate_if.reg_sel), .reg_wdata(u_pwr_gate_if.reg_wdata),
      .reg_rdata(u_pwr_gate_if.reg_rdata)
   );

   // ********************************************
   // tasks
   // ********************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // bounded wait, noting what the device shows during the access
   task automatic wait_ready;
      int n;
      n = 0;
      do
      begin
         @(negedge clock);
         sel_seen  |= flash_selected;
         wlow_seen |= !flash_write_strobe_n;
         rlow_seen |= !flash_read_strobe_n;
         valid_low |= !pld_outputs_valid;
         n++;
      end while (ready !== 1'b1 && n < 400);
      if (ready !== 1'b1)
         check({7'h00, ready}, 8'h01);
   endtask

   task automatic op(input logic w, input logic r, input logic wm,
                     input logic s, input logic [7:0] d, input logic [7:0] e);
      wait_ready();
      if (w || r)
         note_q.push_back({r, e});
      sel_seen  = 1'b0;
      wlow_seen = 1'b0;
      rlow_seen = 1'b0;
      valid_low = 1'b0;
      @(posedge clock);
      cmd_write      <= w;
      cmd_read       <= r;
      cmd_warm_reset <= wm;
      cmd_sel        <= s;
      cmd_wdata      <= d;
      @(posedge clock);
      cmd_write      <= 1'b0;
      cmd_read       <= 1'b0;
      cmd_warm_reset <= 1'b0;
      wait_ready();
   endtask

   // ********************************************
   // clock, pin toggling, result watcher, watchdog
   // ********************************************
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // quarter rate, so stages two and three of the pin filter can agree
   always @(posedge clock)
   begin
      clk_ph <= ~clk_ph;
      if (clk_en && clk_ph)
         pld_clock_input <= ~pld_clock_input;
   end

   always @(posedge clock)
      if (done === 1'b1)
      begin
         if (note_q.size() == 0)
            check(8'h00, 8'h01);
         else
         begin
            note = note_q.pop_front();
            if (note[8])
               check(rdata, note[7:0]);
         end
      end

   initial
   begin
      #100000;
      n_mismatch++;
      summarize();
   end

   // ********************************************
   // main sequence
   // ********************************************
   initial
   begin
      seed = 34655;
      {resetn, cmd_write, cmd_read, cmd_warm_reset, cmd_sel} = 5'h00;
      {clk_ph, clk_en, pld_clock_input, port_d_pin_zero} = 4'h0;
      port_c_pin_seven = 1'b0;
      {mcell_next, mcell_clear_eq, mcell_preset_eq} = 3'h0;
      cmd_wdata  = 8'h00;
      n_mismatch = 0;
      n_tests    = 0;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      wait_ready();
      check({7'h00, flash_read_array}, 8'h01);
      check({7'h00, output_macrocell}, 8'h00);
      check({7'h00, pld_outputs_valid}, 8'h01);
      op(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
      op(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 8'h00);
      check({7'h00, rlow_seen}, 8'h01);
      $display("test reset_state done");

      @(posedge clock);
      port_d_pin_zero  <= 1'b1;
      port_c_pin_seven <= 1'b1;
      for (int k = 0; k < 7; k++)
      begin
         v = (k < 5) ? 8'(8'h04 << k) :
             (k == 5) ? (8'($random(seed)) & REG_B_USED_MASK) : 8'h00;
         op(1'b1, 1'b0, 1'b0, 1'b1, v, 8'h00);
         check({7'h00, sel_seen}, 8'h01);
         check({7'h00, wlow_seen}, 8'h01);
         check({7'h00, flash_selected}, 8'h00);
         repeat (8) @(negedge clock);
         check({3'h0, pld_array_inputs}, {3'h0, 5'h1B & ~v[6:2]});
         op(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, v);
         check({7'h00, rlow_seen}, 8'h01);
      end
      $display("test input_blocking done");

      @(posedge clock);
      clk_en <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         op(1'b1, 1'b0, 1'b0, 1'b0, k ? 8'h20 : 8'h10, 8'h00);
         arr_seen = 1'b0;
         mc_seen  = 1'b0;
         repeat (16)
         begin
            @(negedge clock);
            arr_seen |= pld_array_clock;
            mc_seen  |= pld_mcell_clock;
         end
         check({6'h00, arr_seen, mc_seen}, k ? 8'h02 : 8'h01);
      end
      $display("test clock_gating done");

      @(posedge clock);
      clk_en <= 1'b0;
      op(1'b1, 1'b0, 1'b0, 1'b0, 8'h08, 8'h00);
      repeat (30) @(negedge clock);
      check({7'h00, pld_standby}, 8'h01);
      @(posedge clock);
      port_d_pin_zero <= 1'b0;
      repeat (15) @(negedge clock);
      check({7'h00, pld_standby}, 8'h00);
      op(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
      repeat (30) @(negedge clock);
      check({7'h00, pld_standby}, 8'h00);
      $display("test standby done");

      // macrocell clock kept running, whichever clock the flop uses
      @(posedge clock);
      clk_en <= 1'b1;
      foreach (mc_tbl[i])
      begin
         @(posedge clock);
         {mcell_next, mcell_clear_eq, mcell_preset_eq} <= mc_tbl[i][3:1];
         repeat (12) @(negedge clock);
         check({7'h00, output_macrocell}, {7'h00, mc_tbl[i][0]});
      end
      $display("test macrocell done");

      v = 8'($random(seed));
      op(1'b1, 1'b0, 1'b0, 1'b0, v, 8'h00);
      op(1'b1, 1'b0, 1'b0, 1'b1, v & REG_B_USED_MASK, 8'h00);
      @(posedge clock);
      // preset, not the clock: random reg a bits may block the clock
      {mcell_next, mcell_clear_eq, mcell_preset_eq} <= 3'b001;
      op(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
      check({7'h00, valid_low}, 8'h00);
      check({7'h00, output_macrocell}, 8'h01);
      op(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, v & REG_A_USED_MASK);
      op(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, v & REG_B_USED_MASK);
      $display("test warm_reset done");
      summarize();
   end
endmodule
`default_nettype wire
